/* File: include/flash_ctl_regs.vh */
// register offsets, field positions, reset values and array geometry for the flash control block
`ifndef FLASH_CTL_REGS_VH
`define FLASH_CTL_REGS_VH

// register word addresses on the plain port
`define REG_CONFIG 4'h0
`define REG_CONTROL 4'h1
`define REG_STATUS 4'h2

// module configuration register fields
`define CFG_ARRAY_OPEN_BIT 4
`define SHADOW_ARRAY_OPEN_BIT 4

// control register fields
`define CTL_PROGRAM_SELECT_BIT 0
`define CTL_ERASE_SELECT_BIT 1
`define CTL_HIGH_VOLTAGE_ENABLE_BIT 2

// status register fields
`define STS_ROW_LATCHED_BIT 0
`define STS_PROG_COUNT_LSB 1

// control reset value
`define CONTROL_RESET 8'h00

// array geometry: 4096 words of 16 bits, rows of 32 words
`define ARRAY_ADDR_W 13
`define ROW_WORD_BITS 5
`define BOOT_BLOCK_BASE 13'h1C00

`endif

/* File: rtl/flash_array_mem.v */
// flash word array with read, word program (one to zero) and erase ports
`timescale 1ns/1ps
module flash_array_mem
(
    core_clk,
    rd_word_addr,
    rd_data,
    prog_en,
    prog_word_addr,
    prog_data,
    erase_en,
    erase_keep_boot,
    boot_base
);
    input wire core_clk;
    input wire [11:0] rd_word_addr; // word index for reads
    output wire [15:0] rd_data; // combinational read data
    input wire prog_en; // one-cycle program strobe
    input wire [11:0] prog_word_addr; // word index to program
    input wire [15:0] prog_data; // data word, zeros get programmed
    input wire erase_en; // one-cycle erase strobe
    input wire erase_keep_boot; // leave boot block untouched
    input wire [11:0] boot_base; // first word of boot block

    reg [15:0] mem [0:4095]; // array storage, no reset: nonvolatile
    integer i;

    assign rd_data = mem[rd_word_addr];

    ////////////////////////////////////////////////////////////////////
    // program clears bits only; erase sets every affected bit to one
    always @(posedge core_clk)
    begin
        if (erase_en)
        begin
            for (i = 0; i < 4096; i = i + 1)
            begin
                if (!(erase_keep_boot && (i[11:0] >= boot_base)))
                begin
                    mem[i] <= 16'hFFFF;
                end
            end
        end
        else if (prog_en)
        begin
            mem[prog_word_addr] <= mem[prog_word_addr] & prog_data;
        end
    end
endmodule

/* File: rtl/flash_program_erase_control.v */
// flash array access with program and erase sequencing and protection
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "flash_ctl_regs.vh"

// Functional notes
// - byte or aligned read one cycle, misaligned two
// - plain writes ignored, reads answered
// - erased reads one; program clears; erase sets
// - rows are 32 words on 64-byte boundaries
// - program select latches row on first write
// - boot block words not programmed when protected
// - boot block erased only when protect negated
// - unrelated accesses keep latched sequence state
// - stop or wait aborts program or erase
// - array open at config bit 4 gates operations
// - array open readable; normal mode write zero only
// - array open loaded from shadow bit 4 at reset
// - program and erase select never both set
module flash_program_erase_control
(
    core_clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    arr_addr,
    arr_wdata,
    arr_byte,
    arr_wr,
    arr_rd,
    arr_rdata,
    arr_valid,
    boot_block_protect,
    special_mode,
    stop_wait,
    shadow_word,
    high_voltage_on
);
    input wire core_clk; // bus clock, 50 MHz
    input wire rst_n; // synchronous reset, active low
    input wire [3:0] reg_addr; // register word address
    input wire [7:0] reg_wdata; // register write data
    input wire reg_wr; // register write strobe
    input wire reg_rd; // register read strobe
    output reg [7:0] reg_rdata; // register read data, cycle after strobe
    input wire [12:0] arr_addr; // array byte address
    input wire [15:0] arr_wdata; // array write data
    input wire arr_byte; // byte access when high, word when low
    input wire arr_wr; // array write strobe
    input wire arr_rd; // array read strobe
    output reg [15:0] arr_rdata; // array read data
    output reg arr_valid; // read data valid pulse
    input wire boot_block_protect; // protect boot block, from a pin
    input wire special_mode; // special mode strap, from a pin
    input wire stop_wait; // stop or wait mode entry, from a pin
    input wire [15:0] shadow_word; // nonvolatile shadow word
    output reg high_voltage_on; // charge pump running

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, first stage read only by second
    // the protect, strap and stop pins are slow levels, so two flops suffice
    reg [2:0] pin_s1_q;
    reg [2:0] pin_s2_q;
    wire boot_prot = pin_s2_q[0];
    wire special = pin_s2_q[1];
    wire stop_wait_s = pin_s2_q[2];

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end
        else
        begin
            pin_s1_q <= {stop_wait, special_mode, boot_block_protect};
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control state
    reg array_open_q; // whole-array unlock
    reg shadow_load_q; // shadow copy pending after reset release
    reg program_select_q;
    reg erase_select_q;
    reg high_voltage_enable_q;
    reg row_latched_q; // row or erase address latched
    reg [6:0] row_q; // latched row number
    reg [6:0] prog_count_q; // words programmed in current row

    // protection and stop mode both gate every high-voltage action
    wire ops_allowed = array_open_q && !stop_wait_s;
    wire wr_cfg = reg_wr && (reg_addr == `REG_CONFIG);
    wire wr_ctl = reg_wr && (reg_addr == `REG_CONTROL);
    wire aligned = !arr_addr[0];
    wire [11:0] word_idx = arr_addr[12:1];
    // boot block start as a word index: drop the byte-lane bit
    localparam [12:0] BOOT_BYTE_BASE = `BOOT_BLOCK_BASE;
    wire [11:0] boot_base = BOOT_BYTE_BASE[12:1];
    wire in_boot = word_idx >= boot_base;
    wire in_row = (word_idx[11:`ROW_WORD_BITS] == row_q);

    // program fires on aligned word writes inside the latched row once the pump is on; erase fires on a control write
    wire do_prog = arr_wr && program_select_q && high_voltage_enable_q && row_latched_q
        && aligned && !arr_byte && in_row && !(boot_prot && in_boot)
        && ops_allowed;
    // erase fires as software clears erase select after the erase time;
    // the block does not time it, so the erase completes on that write however short the wait
    wire do_erase = erase_select_q && high_voltage_enable_q && row_latched_q
        && ops_allowed && wr_ctl && !reg_wdata[`CTL_ERASE_SELECT_BIT];

    ////////////////////////////////////////////////////////////////////
    // configuration: array open loaded from shadow then guarded writes
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            array_open_q <= 1'b0;
            shadow_load_q <= 1'b1;
        end
        else if (shadow_load_q)
        begin
            // captured after release since reset may only load constants
            array_open_q <= shadow_word[`SHADOW_ARRAY_OPEN_BIT];
            shadow_load_q <= 1'b0;
        end
        // a one written in normal mode is dropped, so protection only tightens
        else if (wr_cfg)
        begin
            if (special || !reg_wdata[`CFG_ARRAY_OPEN_BIT])
            begin
                array_open_q <= reg_wdata[`CFG_ARRAY_OPEN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control bits and latched sequence state
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            program_select_q <= 1'b0;
            erase_select_q <= 1'b0;
            high_voltage_enable_q <= 1'b0;
            row_latched_q <= 1'b0;
            row_q <= 7'h00;
            prog_count_q <= 7'h00;
        end
        else if (stop_wait_s)
        begin
            // abort drops pump and selects at once
            program_select_q <= 1'b0;
            erase_select_q <= 1'b0;
            high_voltage_enable_q <= 1'b0;
            row_latched_q <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                // a select bit is refused while the other is set
                if (!erase_select_q || !reg_wdata[`CTL_PROGRAM_SELECT_BIT])
                begin
                    program_select_q <= reg_wdata[`CTL_PROGRAM_SELECT_BIT];
                end
                if (!program_select_q && !(reg_wdata[`CTL_PROGRAM_SELECT_BIT]
                    && reg_wdata[`CTL_ERASE_SELECT_BIT]))
                begin
                    erase_select_q <= reg_wdata[`CTL_ERASE_SELECT_BIT];
                end
                // pump only with a select or the pump already on, and an open array
                high_voltage_enable_q <= reg_wdata[`CTL_HIGH_VOLTAGE_ENABLE_BIT]
                    && (program_select_q || erase_select_q || high_voltage_enable_q)
                    && ops_allowed;
                // clearing both selects drops the latched row
                if (!reg_wdata[`CTL_PROGRAM_SELECT_BIT] && !reg_wdata[`CTL_ERASE_SELECT_BIT])
                begin
                    row_latched_q <= 1'b0;
                end
            end
            // first aligned write after select latches address only
            // the pump must be off, so a stray write while programming
            // can never move the row under the charge pump
            if (arr_wr && (program_select_q || erase_select_q) && !row_latched_q
                && aligned && !high_voltage_enable_q)
            begin
                row_latched_q <= 1'b1;
                row_q <= word_idx[11:`ROW_WORD_BITS];
                prog_count_q <= 7'h00;
            end
            else if (do_prog)
            begin
                prog_count_q <= prog_count_q + 7'h01;
            end
            // unrelated reads and writes leave the latch alone
        end
    end

    ////////////////////////////////////////////////////////////////////
    // array storage
    // cell contents carry no reset: they model nonvolatile storage
    reg [11:0] rd_idx; // read word index
    wire [15:0] mem_q;

    flash_array_mem u_mem
    (
        .core_clk(core_clk),
        .rd_word_addr(rd_idx),
        .rd_data(mem_q),
        .prog_en(do_prog),
        .prog_word_addr(word_idx),
        .prog_data(arr_wdata),
        .erase_en(do_erase),
        .erase_keep_boot(boot_prot),
        .boot_base(boot_base)
    );

    ////////////////////////////////////////////////////////////////////
    // read path: misaligned word takes a second cycle
    reg mis_q; // second half pending
    reg [7:0] mis_hi_q; // first byte held
    reg [11:0] mis_idx_q; // next word index
    // a new read during the second cycle of a misaligned read is dropped

    // the second half of a misaligned read looks at the next word
    always @*
    begin
        rd_idx = mis_q ? mis_idx_q : word_idx;
    end

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            arr_rdata <= 16'h0000;
            arr_valid <= 1'b0;
            mis_q <= 1'b0;
            mis_hi_q <= 8'h00;
            mis_idx_q <= 12'h000;
        end
        else if (mis_q)
        begin
            arr_rdata <= {mis_hi_q, mem_q[15:8]};
            arr_valid <= 1'b1;
            mis_q <= 1'b0;
        end
        else if (arr_rd && !arr_byte && !aligned)
        begin
            mis_hi_q <= mem_q[7:0];
            mis_idx_q <= word_idx + 12'h001;
            mis_q <= 1'b1;
            arr_valid <= 1'b0;
        end
        else if (arr_rd)
        begin
            // byte reads return the addressed byte in the low lane
            arr_rdata <= arr_byte ? {8'h00, (aligned ? mem_q[15:8] : mem_q[7:0])}
                : mem_q;
            arr_valid <= 1'b1;
        end
        else
        begin
            arr_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read port and pump output
    // the pump output trails its enable by one cycle to come from a flop
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            high_voltage_on <= 1'b0;
        end
        else
        begin
            high_voltage_on <= high_voltage_enable_q;
            if (reg_rd)
            begin
                case (reg_addr)
                    `REG_CONFIG: reg_rdata <= {3'h0, array_open_q, 4'h0};
                    `REG_CONTROL: reg_rdata <= {5'h00, high_voltage_enable_q,
                        erase_select_q, program_select_q};
                    // status: words programmed above the row-latched flag
                    `REG_STATUS: reg_rdata <= {prog_count_q, row_latched_q};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

/* File: test/cpu_bus_model.sv */
// cpu side model issuing array reads and writes
`timescale 1ns/1ps
module cpu_bus_model
(
    input logic core_clk,
    output logic [12:0] arr_addr,
    output logic [15:0] arr_wdata,
    output logic arr_byte,
    output logic arr_wr,
    output logic arr_rd,
    input logic [15:0] arr_rdata,
    input logic arr_valid
);
    initial {arr_addr, arr_wdata, arr_byte, arr_wr, arr_rd} = '0;
    ////////////////////////////////////////
    // word write; released data flips so a stale value never passes
    task automatic wr(input logic [12:0] a, input logic [15:0] d);
        @(posedge core_clk);
        arr_addr <= {a[12:1], 1'b0};
        arr_wdata <= d;
        arr_byte <= 1'b0;
        arr_wr <= 1'b1;
        @(posedge core_clk);
        arr_wr <= 1'b0;
        arr_wdata <= ~d;
    endtask
    // read, returns data and the count of cycles to the valid pulse
    task automatic rd(input logic [12:0] a, input logic b, output logic [15:0] d, output int n);
        @(posedge core_clk);
        arr_addr <= a;
        arr_byte <= b;
        arr_rd <= 1'b1;
        @(posedge core_clk);
        arr_rd <= 1'b0;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (n < 4 && arr_valid !== 1'b1);
        d = arr_rdata;
    endtask
endmodule

/* File: test/flash_ctl_asserts.sv */
// port assertions for the flash program and erase control block
`timescale 1ns/1ps
`include "flash_ctl_regs.vh"
module flash_ctl_asserts
(
    input logic core_clk,
    input logic rst_n,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    input logic [12:0] arr_addr,
    input logic arr_byte,
    input logic arr_rd,
    input logic arr_valid,
    input logic stop_wait,
    input logic high_voltage_on
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // misaligned word read needs a second cycle
    wire mis = arr_rd && !arr_byte && arr_addr[0];
    ////////////////////////////////////////
    AST_READ_ONE: assert property (arr_rd && !mis |=> arr_valid)
        else $error("aligned read not answered next cycle");
    AST_READ_TWO: assert property (mis |=> !arr_valid ##1 arr_valid)
        else $error("misaligned read not answered in two cycles");
    AST_VALID_CAUSE: assert property (arr_valid |-> $past(arr_rd) || $past(arr_rd, 2))
        else $error("read data valid without a read");
    AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("register read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (
        reg_rd && reg_addr > `REG_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped register read not zero");
    AST_SELECT_EXCL: assert property (
        reg_rd && reg_addr == `REG_CONTROL |=> !(reg_rdata[0] && reg_rdata[1]))
        else $error("program and erase select both set");
    AST_STOP_ABORT: assert property (stop_wait [*5] |=> !high_voltage_on)
        else $error("pump still on in stop mode");
    AST_HV_CAUSE: assert property (
        $rose(high_voltage_on) |-> $past(reg_wr, 2) && $past(reg_wdata[2], 2)
        && $past(reg_addr, 2) == `REG_CONTROL)
        else $error("pump started without a control write");
    COV_MIS: cover property (mis ##2 arr_valid);
    COV_HV: cover property ($rose(high_voltage_on));
    COV_STOP: cover property (stop_wait && high_voltage_on);
endmodule
bind flash_program_erase_control flash_ctl_asserts chk (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .arr_addr, .arr_byte, .arr_rd, .arr_valid, .stop_wait,
    .high_voltage_on);

/* File: test/tb_flash_program_erase_control.sv */
// testbench for the flash program and erase control block
`timescale 1ns/1ps
`include "flash_ctl_regs.vh"
module tb_flash_program_erase_control;
    localparam int US = 50; // cycles per microsecond at 50 MHz
    localparam int ERASE_US = 20; // erase time, free choice
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic boot_block_protect = 1'b0;
    logic special_mode = 1'b0;
    logic stop_wait = 1'b0;
    logic [15:0] shadow = 16'h0010; // nonvolatile shadow word seen at reset
    logic [7:0] reg_rdata;
    logic high_voltage_on, arr_byte, arr_wr, arr_rd, arr_valid;
    logic [12:0] arr_addr;
    logic [15:0] arr_wdata, arr_rdata, rdat;
    logic [31:0] pair;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int lat;
    flash_program_erase_control uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .arr_addr, .arr_wdata, .arr_byte, .arr_wr, .arr_rd, .arr_rdata, .arr_valid,
        .boot_block_protect, .special_mode, .stop_wait, .shadow_word(shadow), .high_voltage_on);
    cpu_bus_model cpu (.core_clk, .arr_addr, .arr_wdata, .arr_byte, .arr_wr, .arr_rd,
        .arr_rdata, .arr_valid);
    initial forever #10 core_clk = ~core_clk;
    ////////////////////////////////////////
    // hang guard: the run needs about 60k cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    function automatic logic [15:0] pat(input int i);
        return 16'hA5C3 ^ 16'(i * 16'h0111);
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e, input string m);
        cmp8(g[15:8], e[15:8], m);
        cmp8(g[7:0], e[7:0], m);
    endtask
    // register strobes last one cycle each
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic creg(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        cmp8(reg_rdata, e, m);
    endtask
    task automatic carr(input logic [12:0] a, input logic [15:0] e, input string m);
        cpu.rd(a, 1'b0, rdat, lat);
        cmp16(rdat, e, m);
        cmp8(8'(lat), 8'h01, "aligned latency");
    endtask
    task automatic wait_us(input int u);
        repeat (u * US) @(posedge core_clk);
    endtask
    // program n words of the row at base, with a busy bus in the middle of rows over 20 words
    task automatic prog(input logic [12:0] base, input int n);
        wreg(`REG_CONTROL, 8'h01);
        cpu.wr(base, 16'h0000);
        wait_us(10);
        wreg(`REG_CONTROL, 8'h05);
        wait_us(5);
        for (int i = 0; i < n; i++)
        begin
            cpu.wr(base + 13'(2 * i), pat(i));
            if (i == 15)
                creg(`REG_STATUS, 8'h21, "status mid row");
            if (i == 20)
                cpu.wr(13'h0080, 16'h0000);
            wait_us(30);
        end
        wreg(`REG_CONTROL, 8'h04);
        wait_us(5);
        wreg(`REG_CONTROL, 8'h00);
        wait_us(1);
    endtask
    task automatic erase();
        wreg(`REG_CONTROL, 8'h02);
        wreg(`REG_CONTROL, 8'h03);
        creg(`REG_CONTROL, 8'h02, "select interlock");
        cpu.wr(13'h0100, 16'h0000);
        wait_us(10);
        wreg(`REG_CONTROL, 8'h06);
        wait_us(ERASE_US);
        wreg(`REG_CONTROL, 8'h04);
        wait_us(5);
        wreg(`REG_CONTROL, 8'h00);
        wait_us(1);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        creg(`REG_CONFIG, 8'h10, "open from shadow");
        creg(4'hF, 8'h00, "unmapped read");
        wreg(`REG_CONFIG, 8'h00);
        creg(`REG_CONFIG, 8'h00, "close array");
        wreg(`REG_CONFIG, 8'h10);
        creg(`REG_CONFIG, 8'h00, "normal reopen");
        wreg(`REG_CONTROL, 8'h01);
        wreg(`REG_CONTROL, 8'h05);
        repeat (3) @(negedge core_clk);
        cmp8({7'h00, high_voltage_on}, 8'h00, "closed pump");
        wreg(`REG_CONTROL, 8'h00);
        special_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        wreg(`REG_CONFIG, 8'h10);
        creg(`REG_CONFIG, 8'h10, "special reopen");
        $display("test config done");
        erase();
        carr(13'h0000, 16'hFFFF, "erased word");
        carr(13'h1C00, 16'hFFFF, "boot erased");
        cpu.wr(13'h0080, 16'h0000);
        carr(13'h0080, 16'hFFFF, "plain write");
        prog(13'h1C00, 1);
        carr(13'h1C00, pat(0), "boot open program");
        @(posedge core_clk);
        boot_block_protect <= 1'b1;
        repeat (3) @(posedge core_clk);
        prog(13'h1C40, 1);
        carr(13'h1C40, 16'hFFFF, "boot guarded");
        prog(13'h0040, 32);
        for (int i = 0; i < 32; i++)
            carr(13'h0040 + 13'(2 * i), pat(i), "row word");
        carr(13'h0080, 16'hFFFF, "outside row");
        pair = {pat(0), pat(1)};
        cpu.rd(13'h0041, 1'b0, rdat, lat);
        cmp16(rdat, pair[23:8], "misaligned data");
        cmp8(8'(lat), 8'h02, "misaligned latency");
        cpu.rd(13'h0043, 1'b1, rdat, lat);
        cmp8(rdat[7:0], pair[7:0], "byte read");
        cmp8(8'(lat), 8'h01, "byte latency");
        $display("test program done");
        erase();
        carr(13'h0040, 16'hFFFF, "row erased");
        carr(13'h1C00, pat(0), "boot kept");
        wreg(`REG_CONTROL, 8'h01);
        cpu.wr(13'h0000, 16'h0000);
        wait_us(10);
        wreg(`REG_CONTROL, 8'h05);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        cmp8({7'h00, high_voltage_on}, 8'h01, "pump on");
        @(posedge core_clk);
        stop_wait <= 1'b1;
        repeat (6) @(posedge core_clk);
        stop_wait <= 1'b0;
        @(negedge core_clk);
        cmp8({7'h00, high_voltage_on}, 8'h00, "stop pump");
        creg(`REG_CONTROL, 8'h00, "stop selects");
        cpu.wr(13'h0000, 16'h0000);
        carr(13'h0000, 16'hFFFF, "after abort");
        $display("test erase and abort done");
        // second reset with the shadow bit programmed keeps the array shut
        @(posedge core_clk);
        shadow <= 16'h0000;
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        creg(`REG_CONFIG, 8'h00, "closed from shadow");
        creg(`REG_CONTROL, 8'h00, "control after reset");
        $display("test shadow reset done");
        close_out();
    end
endmodule
